// *** hw/trace_mem_cfg.svh ***
// Constants for the trace memory select and overflow unit
// Overview of operation
// - Each of the four trace memories holds 256 bytes, each byte split over two 4-bit halves.
// - The memory unit answers only while the power good flag and the data field select are both 1.
// - A selection byte written by the processor is captured into the select latch on write strobe with memory select strobe.
// - Select latch bits 3..0 are the read enables, one per memory, choosing the memory read out.
// - Select latch bits 7..4 are the write enables, one per memory, blocked while no write strobe is active.
// - The location in every memory is chosen by the shared 8-bit address.
// - Only the accumulator memory takes outside data; stored trace memories are only loaded from the accumulator.
// - Accumulator write data comes from the latched acquisition bus or the latched system data bus.
// - The source select line picks acquisition data when 1 and system bus data when 0.
// - The two source latches are enabled by complementary signals, never both at once.
// - Samples are 8-bit two's complement, with a clear top bit meaning positive and -128 the most negative.
// - Overflow is recognised when the byte equals the largest positive or the most negative code.
// - Overflow is found by inverting the top bit and xor-comparing it with the seven lower bits, all equal meaning overflow.
// - The overflow flag is driven out to the intensity pulse logic so the trace can blink.
// - The processor bus timing runs from a 2.5 MHz reference that paces the memory strobes.
`ifndef TRACE_MEM_CFG_SVH
`define TRACE_MEM_CFG_SVH
`define MEM_DEPTH 256
`define MEM_AW 8
`define NUM_MEM 4
`define NIB_W 4
`define CLK_SYS_HZ 25000000
`define BUS_CLK_HZ 2500000
`define BUS_DIV (`CLK_SYS_HZ / `BUS_CLK_HZ)
`define DIV_W 4
`define OFS_CTRL 8'h00
`define OFS_SELECT 8'h04
`define OFS_ADDR 8'h08
`define OFS_DATA 8'h0C
`define OFS_STATUS 8'h10
`define OFS_MASK 8'h14
`define CTRL_SRC_BIT 0
`define CTRL_PG_BIT 1
`define CTRL_DFS_BIT 2
`define ST_OVL_BIT 0
`define ST_ACQ_BIT 1
`define ST_LIVE_BIT 8
`define CTRL_RST 3'h0
`define SEL_RST 8'h00
`define IRQ_W 2
`define MAX_POS 8'h7F
`define MIN_NEG 8'h80
`define HTRANS_NONSEQ 2'h2
`endif

// *** hw/trace_mem_pkg.sv ***
// Types shared by the trace memory unit
package trace_mem_pkg;
  typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_READ} bus_state_t;
  typedef logic [7:0] sample_t;
endpackage

// *** hw/mem_port_if.sv ***
// Port between the controller and the trace memory bank
`timescale 1ns/1ps
interface mem_port_if;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [3:0] wr_en;
  logic [3:0] rd_en;
  logic [7:0] rdata;
  modport ctrl (output addr, output wdata, output wr_en, output rd_en, input rdata);
  modport bank (input addr, input wdata, input wr_en, input rd_en, output rdata);
endinterface

// *** hw/trace_ram_bank.sv ***
// Four 256-byte trace memories built from nibble-wide halves
`timescale 1ns/1ps
`include "trace_mem_cfg.svh"
module trace_ram_bank
(
  input wire logic clk_sys,
  input wire logic rstn,
  mem_port_if.bank mp
);
  // Low and high nibble halves per memory; index 0 is the accumulator
  logic [`NIB_W-1:0] mem_lo [`NUM_MEM][`MEM_DEPTH];
  logic [`NIB_W-1:0] mem_hi [`NUM_MEM][`MEM_DEPTH];
  logic [7:0] rdata_q;

  // Accumulator takes outside data, stored memories copy the accumulator
  always_ff @(posedge clk_sys)
  begin
    if (mp.wr_en[0])
    begin
      mem_lo[0][mp.addr] <= mp.wdata[3:0];
      mem_hi[0][mp.addr] <= mp.wdata[7:4];
    end
    for (int i = 1; i < `NUM_MEM; i++)
    begin
      if (mp.wr_en[i])
      begin
        mem_lo[i][mp.addr] <= mem_lo[0][mp.addr];
        mem_hi[i][mp.addr] <= mem_hi[0][mp.addr];
      end
    end
  end

  // Lowest enabled memory wins if software enables several for reading
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
      rdata_q <= 8'h00;
    else if (mp.rd_en != 4'h0)
    begin
      rdata_q <= 8'h00;
      for (int i = `NUM_MEM - 1; i >= 0; i--)
        if (mp.rd_en[i])
          rdata_q <= {mem_hi[i][mp.addr], mem_lo[i][mp.addr]};
    end
  end
  assign mp.rdata = rdata_q;

  copy_from_acc_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    mp.wr_en[1] && !mp.wr_en[0] |=> mem_lo[1][$past(mp.addr)] == mem_lo[0][$past(mp.addr)])
    else $error("stored memory not loaded from accumulator");
endmodule

// *** hw/trace_memory_select_overflow.sv ***
// Trace memory unit: AHB-Lite registers, select latch, source mux, overflow
//
// Implementation choices: the register addresses and register access over AHB-Lite.
`timescale 1ns/1ps
`include "trace_mem_cfg.svh"
module trace_memory_select_overflow
(
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic [7:0] acquisition_output_bus,
  input wire logic acq_data_ready,
  output logic [3:0] memory_read_enables,
  output logic [3:0] memory_write_enables,
  output logic overflow_flag,
  output logic bus_clk_out,
  output logic irq
);
  mem_port_if mp ();

  logic [`DIV_W-1:0] div_q;
  logic [2:0] ctrl_q;
  logic [7:0] sel_q, addr_q, dph_addr_q;
  logic [7:0] acq_s1_q, acq_s2_q, acq_s3_q;
  trace_mem_pkg::sample_t acq_latch_q, sys_latch_q, ovl_byte;
  trace_mem_pkg::bus_state_t state_q;
  logic [31:0] hrdata_q;
  logic [`IRQ_W-1:0] status_q, mask_q;
  logic [3:0] wr_out_q, wr_en, rd_en;
  logic hready_q, dph_write_q, reg_wr_q, irq_q, ovl_q, clk_out_q, wait_old_q;
  logic rdy_s1_q, rdy_s2_q, rdy_s3_q, rdy_stable_q, acq_pend_q;
  logic tick, unit_on, src_acq, acq_le, sys_le, addr_take, rdy_rise;
  logic mem_go, bus_wr_stb, acq_wr_stb, wr_stb, ovl_upd, ovl_seen, acq_stored;

  // Overflow when inverted top bit equals all seven lower bits
  function automatic logic ovl_code(input logic [7:0] b);
    ovl_code = ~|({7{~b[7]}} ^ b[6:0]);
  endfunction

  // Register read mux for plain registers; unmapped reads as zero
  function automatic logic [31:0] reg_read(input logic [7:0] ofs);
    reg_read = 32'h0000_0000;
    unique case (ofs)
      `OFS_CTRL: reg_read = {29'h0000_0000, ctrl_q};
      `OFS_SELECT: reg_read = {24'h00_0000, sel_q};
      `OFS_ADDR: reg_read = {24'h00_0000, addr_q};
      `OFS_STATUS: reg_read = {23'h00_0000, ovl_q, 6'h00, status_q};
      `OFS_MASK: reg_read = {30'h0000_0000, mask_q};
      default: reg_read = 32'h0000_0000;
    endcase
  endfunction

  trace_ram_bank bank
  (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .mp(mp)
  );

  // Bus reference divider; memory strobes only fire on its tick
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
      div_q <= '0;
    else if (div_q == `DIV_W'(`BUS_DIV - 1))
      div_q <= '0;
    else
      div_q <= div_q + `DIV_W'(1);
  end
  assign tick = (div_q == `DIV_W'(`BUS_DIV - 1));

  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
      clk_out_q <= 1'b0;
    else
      clk_out_q <= (div_q < `DIV_W'(`BUS_DIV / 2));
  end

  // Three-stage pin synchronisers; a change counts once stages two and three agree
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      acq_s1_q <= 8'h00;
      acq_s2_q <= 8'h00;
      acq_s3_q <= 8'h00;
      rdy_s1_q <= 1'b0;
      rdy_s2_q <= 1'b0;
      rdy_s3_q <= 1'b0;
      rdy_stable_q <= 1'b0;
    end
    else
    begin
      acq_s1_q <= acquisition_output_bus;
      acq_s2_q <= acq_s1_q;
      acq_s3_q <= acq_s2_q;
      rdy_s1_q <= acq_data_ready;
      rdy_s2_q <= rdy_s1_q;
      rdy_s3_q <= rdy_s2_q;
      if (rdy_s2_q == rdy_s3_q)
        rdy_stable_q <= rdy_s3_q;
    end
  end

  // Ready edge; the sample is taken only here, as the released bus may already differ
  assign rdy_rise = (rdy_s2_q == rdy_s3_q) & rdy_s3_q & ~rdy_stable_q;
  assign unit_on = ctrl_q[`CTRL_PG_BIT] & ctrl_q[`CTRL_DFS_BIT];
  assign src_acq = ctrl_q[`CTRL_SRC_BIT];
  // Complementary latch enables keep the two sources from feeding the accumulator lines at once
  assign acq_le = src_acq;
  assign sys_le = ~src_acq;
  assign addr_take = hsel & hready & htrans[1];

  // Data window access completes on a tick, never in the first wait cycle,
  // so the system latch already holds hwdata when the memory is written
  assign mem_go = (state_q == trace_mem_pkg::ST_WAIT) & tick & wait_old_q;
  assign bus_wr_stb = mem_go & dph_write_q;
  assign acq_wr_stb = tick & acq_pend_q & (state_q == trace_mem_pkg::ST_IDLE) & unit_on;
  assign wr_stb = bus_wr_stb | acq_wr_stb;
  // Write enables are blocked outside a write strobe
  assign wr_en = wr_stb ? sel_q[7:4] : 4'h0;
  assign rd_en = (mem_go & ~dph_write_q) ? sel_q[3:0] : 4'h0;
  assign mp.addr = addr_q;
  assign mp.wdata = src_acq ? acq_latch_q : sys_latch_q;
  assign mp.wr_en = wr_en;
  assign mp.rd_en = rd_en;

  // Source latches, loaded only while their enable is high
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      acq_latch_q <= 8'h00;
      sys_latch_q <= 8'h00;
    end
    else
    begin
      if (acq_le && rdy_rise)
        acq_latch_q <= acq_s3_q;
      if (sys_le && state_q == trace_mem_pkg::ST_WAIT && dph_write_q)
        sys_latch_q <= hwdata[7:0];
    end
  end

  // New acquisition sample waits for the next free tick
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
      acq_pend_q <= 1'b0;
    else if (rdy_rise && src_acq)
      acq_pend_q <= 1'b1;
    else if (acq_wr_stb)
      acq_pend_q <= 1'b0;
  end

  // AHB-Lite data-phase sequencer
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      state_q <= trace_mem_pkg::ST_IDLE;
      hready_q <= 1'b1;
      hrdata_q <= 32'h0000_0000;
      dph_addr_q <= 8'h00;
      dph_write_q <= 1'b0;
      reg_wr_q <= 1'b0;
      wait_old_q <= 1'b0;
    end
    else
    begin
      wait_old_q <= (state_q == trace_mem_pkg::ST_WAIT);
      unique case (state_q)
        trace_mem_pkg::ST_IDLE:
        begin
          reg_wr_q <= 1'b0;
          if (addr_take)
          begin
            dph_addr_q <= haddr[7:0];
            dph_write_q <= hwrite;
            // Only the data window stalls, and only while the unit is on
            if (haddr[7:0] == `OFS_DATA && unit_on && haddr[31:8] == 24'h00_0000)
            begin
              state_q <= trace_mem_pkg::ST_WAIT;
              hready_q <= 1'b0;
            end
            else
            begin
              reg_wr_q <= hwrite && haddr[31:8] == 24'h00_0000;
              hrdata_q <= (haddr[31:8] == 24'h00_0000) ? reg_read(haddr[7:0]) : 32'h0000_0000;
            end
          end
        end
        trace_mem_pkg::ST_WAIT:
        begin
          if (mem_go)
          begin
            if (dph_write_q)
            begin
              state_q <= trace_mem_pkg::ST_IDLE;
              hready_q <= 1'b1;
            end
            else
              state_q <= trace_mem_pkg::ST_READ;
          end
        end
        trace_mem_pkg::ST_READ:
        begin
          hrdata_q <= {24'h00_0000, mp.rdata};
          hready_q <= 1'b1;
          state_q <= trace_mem_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Control and address registers
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      ctrl_q <= `CTRL_RST;
      addr_q <= 8'h00;
      mask_q <= '0;
    end
    else if (reg_wr_q)
    begin
      if (dph_addr_q == `OFS_CTRL)
        ctrl_q <= hwdata[2:0];
      if (dph_addr_q == `OFS_ADDR)
        addr_q <= hwdata[7:0];
      if (dph_addr_q == `OFS_MASK)
        mask_q <= hwdata[`IRQ_W-1:0];
    end
  end

  // Select latch: register write acts as write strobe with select strobe
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
      sel_q <= `SEL_RST;
    else if (reg_wr_q && dph_addr_q == `OFS_SELECT)
      sel_q <= hwdata[7:0];
  end

  // Overflow is judged on every byte read out and every byte written into the accumulator
  assign ovl_upd = (state_q == trace_mem_pkg::ST_READ) | (wr_stb & sel_q[4]);
  assign ovl_byte = (state_q == trace_mem_pkg::ST_READ) ? mp.rdata : mp.wdata;
  assign ovl_seen = ovl_upd & ovl_code(ovl_byte);
  assign acq_stored = acq_wr_stb & sel_q[4];

  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
      ovl_q <= 1'b0;
    else if (ovl_upd)
      ovl_q <= ovl_code(ovl_byte);
  end

  // Sticky status, write one to clear; a new event beats the clear
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
      status_q <= '0;
    else
    begin
      if (reg_wr_q && dph_addr_q == `OFS_STATUS)
        status_q <= status_q & ~hwdata[`IRQ_W-1:0];
      if (ovl_seen)
        status_q[`ST_OVL_BIT] <= 1'b1;
      if (acq_stored)
        status_q[`ST_ACQ_BIT] <= 1'b1;
    end
  end

  // Registered pin outputs
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      irq_q <= 1'b0;
      wr_out_q <= 4'h0;
    end
    else
    begin
      irq_q <= |(status_q & mask_q);
      wr_out_q <= wr_en;
    end
  end

  assign hreadyout = hready_q;
  assign hrdata = hrdata_q;
  assign hresp = 1'b0;
  assign memory_read_enables = sel_q[3:0];
  assign memory_write_enables = wr_out_q;
  assign overflow_flag = ovl_q;
  assign bus_clk_out = clk_out_q;
  assign irq = irq_q;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  sequence tick_gap_s;
    !tick [*8] ##1 !tick;
  endsequence
  sequence read_walk_s;
    ##1 (state_q == trace_mem_pkg::ST_READ) ##1 hready_q;
  endsequence

  tick_period_a: assert property (tick |=> tick_gap_s ##1 tick)
    else $error("bus tick period wrong");
  sel_latch_a: assert property (reg_wr_q && dph_addr_q == `OFS_SELECT
    |=> sel_q == $past(hwdata[7:0]))
    else $error("select byte not captured");
  rd_enable_a: assert property (memory_read_enables == sel_q[3:0])
    else $error("read enables differ from latch");
  wr_gate_a: assert property (wr_out_q != 4'h0 |-> $past(wr_stb))
    else $error("write enable without strobe");
  unit_gate_a: assert property (wr_stb |-> unit_on)
    else $error("memory strobed while unit off");
  src_route_a: assert property (wr_stb && src_acq |-> mp.wdata == acq_latch_q)
    else $error("acquisition data not routed");
  latch_excl_a: assert property (!sys_le |=> $stable(sys_latch_q))
    else $error("both source latches enabled");
  ovl_code_a: assert property (ovl_upd |=>
    overflow_flag == ($past(ovl_byte) == `MAX_POS || $past(ovl_byte) == `MIN_NEG))
    else $error("overflow flag wrong");
  read_walk_a: assert property (mem_go && !dph_write_q |-> read_walk_s)
    else $error("read data phase did not finish");
endmodule

// *** tb/acq_source_model.sv ***
// Acquisition circuit model that hands samples to the trace memory unit
`timescale 1ns/1ps
module acq_source_model
(
  input wire logic clk_sys,
  input wire logic send,
  input wire logic [7:0] sample,
  input wire logic [3:0] hold,
  output logic [7:0] acquisition_output_bus,
  output logic acq_data_ready
);
  logic [3:0] cnt_q;
  logic [7:0] last_q;

  // Idle state: released bus, no sample pending
  initial
  begin
    cnt_q = 4'h0;
    last_q = 8'h00;
    acquisition_output_bus = 8'hFF;
    acq_data_ready = 1'b0;
  end

  // Sample stands with ready high for hold+1 cycles, a slow source uses a long hold
  always @(posedge clk_sys)
  begin
    if (send)
    begin
      acquisition_output_bus <= sample;
      last_q <= sample;
      acq_data_ready <= 1'b1;
      cnt_q <= hold;
    end
    else if (cnt_q != 4'h0)
      cnt_q <= cnt_q - 4'h1;
    else
    begin
      // Released bus shows the inverse so a late latch cannot match by luck
      acq_data_ready <= 1'b0;
      acquisition_output_bus <= ~last_q;
    end
  end
endmodule

// *** tb/trace_memory_select_overflow_tb.sv ***
// Self-checking bench for the trace memory select and overflow unit
`timescale 1ns/1ps
`include "trace_mem_cfg.svh"
`define CHECK(nm, ex, got) begin samples_checked++; if ((got) !== (ex)) begin err_count++; \
  $display("BAD %s expected %h seen %h", nm, ex, got); end end
module trace_memory_select_overflow_tb;
  localparam logic [31:0] a_ctrl = {24'h00_0000, `OFS_CTRL};
  localparam logic [31:0] a_sel = {24'h00_0000, `OFS_SELECT};
  localparam logic [31:0] a_addr = {24'h00_0000, `OFS_ADDR};
  localparam logic [31:0] a_data = {24'h00_0000, `OFS_DATA};
  localparam logic [31:0] a_stat = {24'h00_0000, `OFS_STATUS};
  localparam logic [31:0] a_mask = {24'h00_0000, `OFS_MASK};
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0000_0000;
  wire logic hreadyout;
  wire logic hresp;
  wire logic [31:0] hrdata;
  wire logic [7:0] acq_bus;
  wire logic acq_rdy;
  wire logic [3:0] rd_en;
  wire logic [3:0] wr_en;
  wire logic ovl;
  wire logic bus_clk;
  wire logic irq;
  logic send = 1'b0;
  logic [7:0] send_val = 8'h00;
  logic [3:0] send_hold = 4'h5;
  logic [3:0] we_last = 4'h0;
  logic [31:0] rnd = 32'h4351_39fe;
  logic [7:0] exp_mem [256];
  logic [7:0] alist [12];
  logic [31:0] r;
  logic [7:0] b;
  int err_count = 0;
  int samples_checked = 0;
  int n;
  int hi;

  // 25 MHz system clock
  initial
  begin
    forever #20 clk_sys = ~clk_sys;
  end

  trace_memory_select_overflow dut
  (
    .clk_sys(clk_sys), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .acquisition_output_bus(acq_bus), .acq_data_ready(acq_rdy),
    .memory_read_enables(rd_en), .memory_write_enables(wr_en),
    .overflow_flag(ovl), .bus_clk_out(bus_clk), .irq(irq)
  );

  acq_source_model src
  (
    .clk_sys(clk_sys), .send(send), .sample(send_val), .hold(send_hold),
    .acquisition_output_bus(acq_bus), .acq_data_ready(acq_rdy)
  );

  // Write enables are one-cycle pulses, so remember the last one seen
  always @(negedge clk_sys)
  begin
    if (wr_en !== 4'h0)
      we_last = wr_en;
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  function automatic logic ovl_exp(input logic [7:0] v);
    return (v == 8'h7F) || (v == 8'h80);
  endfunction

  task automatic close_out;
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // Ready is judged at the falling edge, which equals its value at the next rise
  task automatic wait_rdy(output logic [31:0] rd);
    int k;
    k = 0;
    @(negedge clk_sys);
    while (hreadyout !== 1'b1 && k < 200)
    begin
      @(negedge clk_sys);
      k++;
    end
    if (k >= 200)
    begin
      err_count++;
      $display("BAD hready expected 1 seen %b", hreadyout);
      close_out();
    end
    rd = hrdata;
    @(posedge clk_sys);
  endtask

  task automatic ahb(input logic w, input logic [31:0] a, input logic [7:0] d,
                     output logic [31:0] rd);
    logic [31:0] x;
    @(posedge clk_sys);
    hsel <= 1'b1;
    htrans <= `HTRANS_NONSEQ;
    haddr <= a;
    hwrite <= w;
    wait_rdy(x);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h00_0000, d};
    wait_rdy(rd);
  endtask

  task automatic wr(input logic [31:0] a, input logic [7:0] d);
    logic [31:0] x;
    ahb(1'b1, a, d, x);
  endtask

  // Main sequence
  initial
  begin
    repeat (8) @(posedge clk_sys);
    rstn <= 1'b1;
    @(negedge clk_sys);
    `CHECK("rd_en reset", 4'h0, rd_en)
    `CHECK("wr_en reset", 4'h0, wr_en)
    `CHECK("irq reset", 1'b0, irq)
    `CHECK("hresp okay", 1'b0, hresp)
    ahb(1'b0, a_sel, 8'h00, r);
    `CHECK("select reset", 32'h0000_0000, r)
    ahb(1'b0, a_ctrl, 8'h00, r);
    `CHECK("ctrl reset", 32'h0000_0000, r)
    wr(32'h0000_0100, 8'hFF);
    ahb(1'b0, 32'h0000_0100, 8'h00, r);
    `CHECK("unmapped read", 32'h0000_0000, r)
    // Unit off: data window refuses both ways
    wr(a_sel, 8'h11);
    wr(a_addr, 8'h33);
    wr(a_data, 8'h44);
    ahb(1'b0, a_data, 8'h00, r);
    `CHECK("data while off", 32'h0000_0000, r)
    // Bus reference clock period, high plus low time
    for (n = 0; n < 40 && bus_clk !== 1'b0; n++) @(negedge clk_sys);
    for (n = 0; n < 40 && bus_clk !== 1'b1; n++) @(negedge clk_sys);
    for (n = 0; n < 40 && bus_clk !== 1'b0; n++) @(negedge clk_sys);
    hi = n;
    for (n = 0; n < 40 && bus_clk !== 1'b1; n++) @(negedge clk_sys);
    `CHECK("bus clk period", 32'(`BUS_DIV), 32'(hi + n))
    // Unit on, system source; corner codes first, then random bytes
    wr(a_ctrl, 8'h06);
    for (int i = 0; i < 12; i++)
    begin
      rnd = xs(rnd);
      b = (i < 4) ? ((i[1] ? 8'h00 : 8'h7F) ^ (i[0] ? 8'hFF : 8'h00)) : rnd[15:8];
      alist[i] = rnd[7:0];
      exp_mem[alist[i]] = b;
      we_last = 4'h0;
      wr(a_addr, alist[i]);
      wr(a_data, b);
      @(negedge clk_sys);
      `CHECK("we accumulator_memory", 4'h1, we_last)
      `CHECK("ovl after write", ovl_exp(b), ovl)
    end
    `CHECK("rd_en accumulator_memory", 4'h1, rd_en)
    for (int i = 0; i < 12; i++)
    begin
      wr(a_addr, alist[i]);
      ahb(1'b0, a_data, 8'h00, r);
      `CHECK("accumulator_memory read", {24'h00_0000, exp_mem[alist[i]]}, r)
      @(negedge clk_sys);
      `CHECK("ovl after read", ovl_exp(exp_mem[alist[i]]), ovl)
      ahb(1'b0, a_stat, 8'h00, r);
      `CHECK("live ovl", ovl_exp(exp_mem[alist[i]]), r[`ST_LIVE_BIT])
    end
    // Interrupt: clear, unmask, raise by an overflow write, then mask it off
    wr(a_stat, 8'h03);
    wr(a_mask, 8'h01);
    @(negedge clk_sys);
    `CHECK("irq cleared", 1'b0, irq)
    wr(a_addr, alist[11]);
    wr(a_data, 8'h80);
    exp_mem[alist[11]] = 8'h80;
    repeat (2) @(negedge clk_sys);
    `CHECK("irq raised", 1'b1, irq)
    wr(a_mask, 8'h00);
    repeat (2) @(negedge clk_sys);
    `CHECK("irq masked", 1'b0, irq)
    wr(a_stat, 8'h03);
    // Copy accumulator into the three stored memories
    wr(a_sel, 8'hE0);
    @(negedge clk_sys);
    `CHECK("no strobe no we", 4'h0, wr_en)
    we_last = 4'h0;
    wr(a_data, 8'h5A);
    @(negedge clk_sys);
    `CHECK("we stored", 4'hE, we_last)
    for (int k = 0; k < 4; k++)
    begin
      wr(a_sel, 8'h01 << k);
      ahb(1'b0, a_data, 8'h00, r);
      `CHECK("copy read", {24'h00_0000, exp_mem[alist[11]]}, r)
    end
    // Acquisition source: sample reaches the accumulator, bus data is ignored
    wr(a_sel, 8'h11);
    wr(a_ctrl, 8'h07);
    wr(a_addr, alist[3]);
    rnd = xs(rnd);
    @(posedge clk_sys);
    send <= 1'b1;
    send_val <= rnd[7:0];
    send_hold <= 4'h5 + {1'b0, rnd[10:8]};
    @(posedge clk_sys);
    send <= 1'b0;
    r = 32'h0000_0000;
    for (n = 0; n < 20 && r[`ST_ACQ_BIT] !== 1'b1; n++) ahb(1'b0, a_stat, 8'h00, r);
    `CHECK("acq stored flag", 1'b1, r[`ST_ACQ_BIT])
    wr(a_data, ~rnd[7:0]);
    ahb(1'b0, a_data, 8'h00, r);
    `CHECK("acq source data", {24'h00_0000, rnd[7:0]}, r)
    wr(a_ctrl, 8'h06);
    wr(a_data, 8'h3C);
    ahb(1'b0, a_data, 8'h00, r);
    `CHECK("sys source data", 32'h0000_003C, r)
    close_out();
  end
endmodule
